/* logic/gcs_pkg.sv */
// package: register map, field layout and types of the global config/status bank
package gcs_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 32;
   localparam logic [7:0] WRITE_FLAG = 8'h80;
   localparam logic [6:0] ADDR_GLOBAL_CONFIGURATION_FLAGS = 7'h00;
   localparam logic [6:0] ADDR_GLOBAL_STATUS_FLAGS = 7'h01;
   localparam logic [6:0] ADDR_INPUT_PIN_READBACK = 7'h04;
   localparam logic [6:0] ADDR_COIL_OVERRIDE_VALUE = 7'h2D;
   localparam int GLOBAL_CONFIGURATION_FLAGS_W = 18;
   localparam int BIT_SMALL_HYST = 14;
   localparam int BIT_STOP_ENABLE = 15;
   localparam int BIT_DIRECT_MODE = 16;
   localparam int BIT_TEST_MODE = 17;
   localparam logic [GLOBAL_CONFIGURATION_FLAGS_W-1:0] GLOBAL_CONFIGURATION_FLAGS_RESET = 18'h0_0000;
   localparam int STAT_W = 3;
   localparam int STAT_RESET_BIT = 0;
   localparam int STAT_DRV_ERR_BIT = 1;
   localparam int STAT_PUMP_LOW_BIT = 2;
   localparam int COIL_W = 9;
   localparam int COIL_A_LSB = 0;
   localparam int COIL_B_LSB = 16;
   localparam logic [DATA_W-1:0] COIL_RESET = 32'h0000_0000;
   localparam int HYST_SHIFT_NORMAL = 4;
   localparam int HYST_SHIFT_SMALL = 5;
   localparam int LEVEL_W = 5;
   localparam int LEVEL_SCALE_SHIFT = 5;
   localparam int PIN_STEP = 0;
   localparam int PIN_DIR = 1;
   localparam int PIN_CFG_A = 2;
   localparam int PIN_CFG_B = 3;
   localparam int PIN_POWER_STAGE_ENABLE_LOW = 4;
   localparam int PIN_CFG_C = 5;
   localparam int PIN_ONE = 6;
   localparam int VERSION_LSB = 24;
   localparam logic [7:0] VERSION_DEFAULT = 8'h01; // arbitrary neutral value

   typedef struct packed {
      logic test_mode;
      logic direct_mode;
      logic stop_enable;
      logic small_hysteresis;
   } upper_cfg_t;

   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [DATA_W-1:0] wdata;
   } access_t;

   typedef struct packed {
      logic step;
      logic dir;
      logic cfg_a;
      logic cfg_b;
      logic enable_low;
      logic cfg_c;
   } pins_t;
endpackage

/* logic/global_config_status_regs.sv */
// global configuration, status and input readback registers of the driver
// Summary of operation
// - Frequency comparison hysteresis is period/16 with small_hysteresis 0 and period/32 with 1.
// - With stop_enable set and the halt request pin high the sequencer halts, no steps run.
// - In direct mode coil currents come from the coil override register, A low field, B upper.
// - In direct mode currents scale by the standstill level and automatic regulation is off.
// - With test_mode set an analog test signal goes to the dc output pin, chosen by level 1:0.
// - Writing one to a status bit clears it, writing zero leaves it alone.
// - Status bit 0 is set after every chip reset with all registers at their reset values.
// - Status bit 1 sets on power stage shutdown and clears only once temperature is below limit.
// - Status bit 2 latches charge pump undervoltage and the driver stays off while it lasts.
// - The input register returns live pin states with a constant one in bit 6 and bit 7 unused.
// - The input register carries a read-only version field in bits 31 to 24.
// - Every register is zero after power-up reset unless stated otherwise.
`timescale 1ns/1ps
module global_config_status_regs
   import gcs_pkg::*;
#(
   parameter int PERIOD_W = 20,
   parameter logic [7:0] VERSION = VERSION_DEFAULT
) (
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire access_t i_acc,
   output logic [DATA_W-1:0] o_rdata,
   output logic o_rvalid,
   input wire pins_t i_pins,
   input wire logic i_halt_request_pin,
   input wire logic i_drv_shutdown,
   input wire logic i_over_temp,
   input wire logic i_pump_low_voltage_flag,
   input wire logic [LEVEL_W-1:0] i_standstill_current_level,
   input wire logic [PERIOD_W-1:0] i_step_period,
   output logic [PERIOD_W-1:0] o_hyst_amount,
   output logic o_seq_halt,
   output logic o_direct_mode,
   output logic o_auto_regulation_en,
   output logic signed [COIL_W-1:0] o_coil_a_current,
   output logic signed [COIL_W-1:0] o_coil_b_current,
   output logic o_dc_test_en,
   output logic [1:0] o_dc_test_sel,
   output logic o_driver_disable,
   output logic [GLOBAL_CONFIGURATION_FLAGS_W-1:0] o_config
);
   logic [GLOBAL_CONFIGURATION_FLAGS_W-1:0] global_configuration_flags_reg;
   logic [GLOBAL_CONFIGURATION_FLAGS_W-1:0] global_configuration_flags_next;
   logic [DATA_W-1:0] coil_reg;
   logic [DATA_W-1:0] coil_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [PERIOD_W-1:0] hyst_reg;
   logic [PERIOD_W-1:0] hyst_next;
   logic signed [COIL_W-1:0] coil_a_reg;
   logic signed [COIL_W-1:0] coil_a_next;
   logic signed [COIL_W-1:0] coil_b_reg;
   logic signed [COIL_W-1:0] coil_b_next;
   logic [STAT_W-1:0] stat_set;
   logic [STAT_W-1:0] stat_clear;
   logic [STAT_W-1:0] stat_allowed;
   logic [STAT_W-1:0] stat_flags;
   logic is_write;
   logic [ADDR_W-1:0] acc_addr;
   upper_cfg_t ucfg;

   // address decode reused by read and write paths
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
      hit = (a == r);
   endfunction

   function automatic logic signed [COIL_W-1:0] scale(input logic signed [COIL_W-1:0] c,
                                                      input logic [LEVEL_W-1:0] lvl);
      logic signed [COIL_W+LEVEL_W+1:0] prod;
      logic [LEVEL_W+1:0] factor;
      // widen before adding one so the top level does not wrap to zero
      factor = {2'b00, lvl} + (LEVEL_W+2)'(1);
      prod = c * $signed(factor);
      scale = prod[COIL_W+LEVEL_SCALE_SHIFT-1:LEVEL_SCALE_SHIFT];
   endfunction

   assign is_write = i_acc.valid && ((i_acc.addr & WRITE_FLAG) != 8'h00);
   assign acc_addr = i_acc.addr[ADDR_W-1:0];
   assign ucfg = '{test_mode: global_configuration_flags_reg[BIT_TEST_MODE],
                   direct_mode: global_configuration_flags_reg[BIT_DIRECT_MODE],
                   stop_enable: global_configuration_flags_reg[BIT_STOP_ENABLE],
                   small_hysteresis: global_configuration_flags_reg[BIT_SMALL_HYST]};

   always_comb begin
      global_configuration_flags_next = global_configuration_flags_reg;
      coil_next = coil_reg;
      if (is_write && hit(acc_addr, ADDR_GLOBAL_CONFIGURATION_FLAGS)) begin
         global_configuration_flags_next = i_acc.wdata[GLOBAL_CONFIGURATION_FLAGS_W-1:0];
      end else if (is_write && hit(acc_addr, ADDR_COIL_OVERRIDE_VALUE)) begin
         coil_next = i_acc.wdata;
      end
   end

   // status flags; write to 0x01 clears the ones set in wdata
   always_comb begin
      stat_clear = '0;
      if (is_write && hit(acc_addr, ADDR_GLOBAL_STATUS_FLAGS)) begin
         stat_clear = i_acc.wdata[STAT_W-1:0];
      end
      stat_set = '0;
      stat_set[STAT_DRV_ERR_BIT] = i_drv_shutdown;
      stat_set[STAT_PUMP_LOW_BIT] = i_pump_low_voltage_flag;
      stat_allowed = '1;
      stat_allowed[STAT_DRV_ERR_BIT] = !i_over_temp;
   end

   genvar gi;
   generate
      for (gi = 0; gi < STAT_W; gi++) begin : g_flag
         // reset flag comes up set, the others clear
         status_flag #(
            .RESET_VALUE(gi == STAT_RESET_BIT)
         ) u_flag (
            .i_clk(I_CLK),
            .i_arst_n(I_ARST_N),
            .i_set(stat_set[gi]),
            .i_clear(stat_clear[gi]),
            .i_clear_allowed(stat_allowed[gi]),
            .o_flag(stat_flags[gi])
         );
      end
   endgenerate

   // registered read answer, one cycle after the request
   always_comb begin
      rvalid_next = i_acc.valid && !is_write;
      rdata_next = rdata_reg;
      if (rvalid_next) begin
         rdata_next = '0;
         if (hit(acc_addr, ADDR_GLOBAL_CONFIGURATION_FLAGS)) begin
            rdata_next[GLOBAL_CONFIGURATION_FLAGS_W-1:0] = global_configuration_flags_reg;
         end else if (hit(acc_addr, ADDR_GLOBAL_STATUS_FLAGS)) begin
            rdata_next[STAT_W-1:0] = stat_flags;
         end else if (hit(acc_addr, ADDR_INPUT_PIN_READBACK)) begin
            rdata_next[PIN_STEP] = i_pins.step;
            rdata_next[PIN_DIR] = i_pins.dir;
            rdata_next[PIN_CFG_A] = i_pins.cfg_a;
            rdata_next[PIN_CFG_B] = i_pins.cfg_b;
            rdata_next[PIN_POWER_STAGE_ENABLE_LOW] = i_pins.enable_low;
            rdata_next[PIN_CFG_C] = i_pins.cfg_c;
            rdata_next[PIN_ONE] = 1'b1;
            rdata_next[VERSION_LSB +: 8] = VERSION;
         end else if (hit(acc_addr, ADDR_COIL_OVERRIDE_VALUE)) begin
            rdata_next = coil_reg;
         end
      end
   end

   // hysteresis is a shift; 1/16 vs 1/32 needs no divider
   always_comb begin
      if (ucfg.small_hysteresis) begin
         hyst_next = i_step_period >> HYST_SHIFT_SMALL;
      end else begin
         hyst_next = i_step_period >> HYST_SHIFT_NORMAL;
      end
   end

   // coil currents only reach the bridge in direct mode
   always_comb begin
      coil_a_next = '0;
      coil_b_next = '0;
      if (ucfg.direct_mode) begin
         coil_a_next = scale(coil_reg[COIL_A_LSB +: COIL_W],
                             i_standstill_current_level);
         coil_b_next = scale(coil_reg[COIL_B_LSB +: COIL_W],
                             i_standstill_current_level);
      end
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         global_configuration_flags_reg <= GLOBAL_CONFIGURATION_FLAGS_RESET;
         coil_reg <= COIL_RESET;
         rdata_reg <= '0;
         rvalid_reg <= 1'b0;
         hyst_reg <= '0;
         coil_a_reg <= '0;
         coil_b_reg <= '0;
      end else begin
         global_configuration_flags_reg <= global_configuration_flags_next;
         coil_reg <= coil_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         hyst_reg <= hyst_next;
         coil_a_reg <= coil_a_next;
         coil_b_reg <= coil_b_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_rvalid = rvalid_reg;
   assign o_hyst_amount = hyst_reg;
   assign o_coil_a_current = coil_a_reg;
   assign o_coil_b_current = coil_b_reg;
   assign o_config = global_configuration_flags_reg;
   // halt is combinational so a stop takes effect on the very next step edge
   assign o_seq_halt = ucfg.stop_enable && i_halt_request_pin;
   assign o_direct_mode = ucfg.direct_mode;
   assign o_auto_regulation_en = !ucfg.direct_mode;
   assign o_dc_test_en = ucfg.test_mode;
   assign o_dc_test_sel = i_standstill_current_level[1:0];
   // live undervoltage keeps the driver off; the latched bit is only for software
   assign o_driver_disable = i_pump_low_voltage_flag || stat_flags[STAT_DRV_ERR_BIT];
endmodule

/* logic/status_flag.sv */
// one sticky status flag, set by hardware, cleared by writing one
`timescale 1ns/1ps
module status_flag
   import gcs_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_set,
   input wire logic i_clear,
   input wire logic i_clear_allowed,
   output logic o_flag
);
   logic flag_reg;
   logic flag_next;

   always_comb begin
      flag_next = flag_reg;
      if (i_clear && i_clear_allowed) begin
         flag_next = 1'b0;
      end
      // set wins so an event in the clearing cycle is never lost
      if (i_set) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         flag_reg <= RESET_VALUE;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign o_flag = flag_reg;
endmodule

/* verif/gcs_props.sv */
// checker: port-level properties of the global config/status bank
`timescale 1ns/1ps
module gcs_props
   import gcs_pkg::*;
#(
   parameter int PERIOD_W = 20,
   parameter logic [7:0] VERSION = VERSION_DEFAULT
) (
   input wire logic I_CLK,
   input wire logic I_ARST_N,
   input wire access_t i_acc,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic o_rvalid,
   input wire pins_t i_pins,
   input wire logic i_halt_request_pin,
   input wire logic i_drv_shutdown,
   input wire logic i_pump_low_voltage_flag,
   input wire logic [LEVEL_W-1:0] i_standstill_current_level,
   input wire logic [PERIOD_W-1:0] i_step_period,
   input wire logic [PERIOD_W-1:0] o_hyst_amount,
   input wire logic o_seq_halt,
   input wire logic o_direct_mode,
   input wire logic o_auto_regulation_en,
   input wire logic signed [COIL_W-1:0] o_coil_a_current,
   input wire logic o_dc_test_en,
   input wire logic [1:0] o_dc_test_sel,
   input wire logic o_driver_disable,
   input wire logic [GLOBAL_CONFIGURATION_FLAGS_W-1:0] o_config
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);
   // readback order differs from the struct order
   wire [5:0] pin_bits = {i_pins.cfg_c, i_pins.enable_low, i_pins.cfg_b, i_pins.cfg_a,
                          i_pins.dir, i_pins.step};
   halt_follows_a: assert property (
      o_seq_halt == (o_config[15] && i_halt_request_pin)) else $error("halt output mismatch");
   hyst_amount_a: assert property (1 |=> o_hyst_amount == ($past(o_config[14]) ?
      $past(i_step_period) >> 5 : $past(i_step_period) >> 4)) else $error("hysteresis wrong");
   direct_select_a: assert property (o_direct_mode == o_config[16] &&
      o_auto_regulation_en == !o_direct_mode) else $error("direct mode outputs wrong");
   test_output_a: assert property (o_dc_test_en == o_config[17]
      && o_dc_test_sel == i_standstill_current_level[1:0]) else $error("test output wrong");
   coil_idle_a: assert property (!o_direct_mode [*2] |-> o_coil_a_current == 0)
      else $error("coil current outside direct mode");
   read_answer_a: assert property (i_acc.valid |=> o_rvalid == !$past(i_acc.addr[7]))
      else $error("read answer wrong");
   no_answer_a: assert property (!i_acc.valid |=> !o_rvalid)
      else $error("spurious read answer");
   pin_readback_a: assert property (i_acc.valid && i_acc.addr == 8'h04 |=>
      o_rdata == {VERSION, 16'h0000, 2'b01, $past(pin_bits)}) else $error("readback wrong");
   config_write_a: assert property (i_acc.valid && i_acc.addr == 8'h80 |=>
      o_config == $past(i_acc.wdata[17:0])) else $error("config write lost");
   pump_off_a: assert property (i_pump_low_voltage_flag |-> o_driver_disable)
      else $error("driver on during undervoltage");
   shutdown_off_a: assert property (i_drv_shutdown |=> o_driver_disable)
      else $error("driver on after shutdown");
   cover property (i_acc.valid && i_acc.addr == 8'h04 ##1 o_rvalid);
   cover property (o_direct_mode && o_coil_a_current != 0);
   cover property (o_seq_halt);
endmodule

/* verif/global_config_status_regs_tb.sv */
// self-checking bench of the global config/status bank
`timescale 1ns/1ps
module global_config_status_regs_tb;
   import gcs_pkg::*;
   localparam logic [7:0] VER = 8'h5A; // arbitrary value
   logic I_CLK, I_ARST_N, rvalid, halt, shut, hot, pump, seq_halt, dmode, areg, ten, ddis;
   access_t acc;
   pins_t pins;
   logic [DATA_W-1:0] rdata, got;
   logic [4:0] lvl;
   logic [19:0] per, hyst;
   logic signed [COIL_W-1:0] ca, cb;
   logic [1:0] tsel;
   bit ok;
   int n_errors = 0;
   int checked = 0;
   // rows: write address, write data, read address, expected word
   logic [6:0] t_wa [5] = '{7'h00, 7'h2D, 7'h04, 7'h05, 7'h00};
   logic [31:0] t_wd [5] = '{32'hFFFF_FFFF, 32'h01E0_01F0, 32'hFFFF_FFFF, 32'h1234_5678, 0};
   logic [6:0] t_ra [5] = '{7'h00, 7'h2D, 7'h04, 7'h05, 7'h00};
   logic [31:0] t_ex [5] = '{32'h0003_FFFF, 32'h01E0_01F0, {VER, 24'h00_0040}, 0, 0};
   global_config_status_regs #(.PERIOD_W(20), .VERSION(VER)) u_dut (.I_CLK(I_CLK),
      .I_ARST_N(I_ARST_N), .i_acc(acc), .o_rdata(rdata), .o_rvalid(rvalid), .i_pins(pins),
      .i_halt_request_pin(halt), .i_drv_shutdown(shut), .i_over_temp(hot),
      .i_pump_low_voltage_flag(pump), .i_standstill_current_level(lvl), .i_step_period(per),
      .o_hyst_amount(hyst), .o_seq_halt(seq_halt), .o_direct_mode(dmode),
      .o_auto_regulation_en(areg), .o_coil_a_current(ca), .o_coil_b_current(cb),
      .o_dc_test_en(ten), .o_dc_test_sel(tsel), .o_driver_disable(ddis), .o_config());
   host_model u_host (.i_clk(I_CLK), .i_rdata(rdata), .i_rvalid(rvalid), .o_acc(acc));
   initial begin
      I_CLK = 1'b0;
      forever #5 I_CLK = ~I_CLK;
   end
   task automatic close_out;
      $display("errors %0d checked %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic cmpb(input logic g, input logic e);
      cmp({31'h0000_0000, g}, {31'h0000_0000, e});
   endtask
   task automatic rdc(input logic [6:0] a, input logic [31:0] e);
      u_host.rd(a, got, ok);
      if (!ok) begin
         n_errors++;
         close_out();
      end else cmp(got, e);
   endtask
   task automatic rst;
      I_ARST_N = 1'b0;
      repeat (10) @(negedge I_CLK);
      I_ARST_N = 1'b1;
   endtask
   initial begin
      {halt, shut, hot, pump} = 4'h0;
      pins = '0;
      lvl = 5'h1F;
      per = 20'h1_2345;
      rst();
      for (int i = 0; i < 5; i++) begin
         u_host.wr(t_wa[i], t_wd[i]);
         rdc(t_ra[i], t_ex[i]);
      end
      u_host.wr(7'h2D, 32'h0020_01F0);
      rst(); // second reset mid-run
      rdc(7'h01, 32'h0000_0001);
      rdc(7'h2D, 32'h0000_0000);
      @(negedge I_CLK);
      {shut, hot, pump} = 3'h7;
      @(negedge I_CLK);
      {shut, pump} = 2'h0;
      rdc(7'h01, 32'h0000_0007);
      u_host.wr(7'h01, 32'h0000_0006); // bit1 refused while hot
      rdc(7'h01, 32'h0000_0003);
      hot = 1'b0;
      u_host.wr(7'h01, 32'h0000_0002);
      rdc(7'h01, 32'h0000_0001);
      cmpb(ddis, 1'b0);
      u_host.wr(7'h01, 32'h0000_0001);
      rdc(7'h01, 32'h0000_0000);
      @(negedge I_CLK);
      pump = 1'b1;
      #1 cmpb(ddis, 1'b1);
      u_host.wr(7'h00, 32'h0000_8000);
      halt = 1'b1;
      #1 cmpb(seq_halt, 1'b1);
      cmp({12'h000, hyst}, 32'h0000_1234);
      u_host.wr(7'h00, 32'h0000_4000);
      repeat (2) @(negedge I_CLK);
      cmpb(seq_halt, 1'b0);
      cmp({12'h000, hyst}, 32'h0000_091A);
      u_host.wr(7'h2D, 32'h0020_01F0);
      u_host.wr(7'h00, 32'h0001_0000);
      repeat (2) @(negedge I_CLK);
      cmp({14'h0000, ca, cb}, 32'h0003_E020);
      cmpb(areg, 1'b0);
      lvl = 5'h0F;
      repeat (2) @(negedge I_CLK);
      cmp({14'h0000, ca, cb}, 32'h0003_F010);
      u_host.wr(7'h00, 32'h0002_0000);
      for (int j = 0; j < 3; j++) begin
         @(negedge I_CLK);
         lvl = 5'(j);
         #1 cmp({29'h0000_0000, ten, tsel}, 32'(4 + j));
      end
      pins = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      rdc(7'h04, {VER, 24'h00_006D});
      close_out();
   end
   // bounded run guard
   initial begin
      repeat (20000) @(posedge I_CLK);
      n_errors++;
      close_out();
   end
endmodule
bind global_config_status_regs gcs_props #(.PERIOD_W(PERIOD_W), .VERSION(VERSION)) u_props (
   .I_CLK, .I_ARST_N, .i_acc, .o_rdata, .o_rvalid, .i_pins, .i_halt_request_pin, .i_drv_shutdown,
   .i_pump_low_voltage_flag, .i_standstill_current_level, .i_step_period, .o_hyst_amount,
   .o_seq_halt, .o_direct_mode, .o_auto_regulation_en, .o_coil_a_current, .o_dc_test_en,
   .o_dc_test_sel, .o_driver_disable, .o_config);

/* verif/host_model.sv */
// host model: issues single register accesses and collects read answers
`timescale 1ns/1ps
module host_model
   import gcs_pkg::*;
(
   input wire logic i_clk,
   input wire logic [DATA_W-1:0] i_rdata,
   input wire logic i_rvalid,
   output access_t o_acc
);
   initial o_acc = '{1'b0, 8'h00, 32'h0000_0000};
   // released lines carry inverted data so stale values never look valid
   task automatic put(input logic [7:0] a, input logic [DATA_W-1:0] d);
      @(negedge i_clk);
      o_acc <= '{1'b1, a, d};
      @(negedge i_clk);
      o_acc <= '{1'b0, ~a, ~d};
   endtask
   task automatic wr(input logic [6:0] a, input logic [DATA_W-1:0] d);
      put(WRITE_FLAG | {1'b0, a}, d);
   endtask
   task automatic rd(input logic [6:0] a, output logic [DATA_W-1:0] d, output bit ok);
      ok = 1'b0;
      d = 32'h0000_0000;
      put({1'b0, a}, 32'h0000_0000);
      // answer stands between two rising edges, so look at falling edges only
      for (int k = 0; k < 3 && !ok; k++) begin
         if (i_rvalid === 1'b1) begin
            ok = 1'b1;
            d = i_rdata;
         end else begin
            @(negedge i_clk);
         end
      end
   endtask
endmodule
